// File: src/exec_map.vh
/*
  constants for the increment-skip / inclusive-or / long-call execution block.
  assumes nothing: definitions only.
*/
`ifndef EXEC_MAP_VH
`define EXEC_MAP_VH

// phases of one instruction cycle
`define PH_DECODE 2'h0
`define PH_READ 2'h1
`define PH_PROCESS 2'h2
`define PH_WRITE 2'h3
`define PH_STEP 2'h1

// opcode fields
`define OP7_HI 15
`define OP7_LO 9
`define OP8_LO 8
`define DEST_BIT 8
`define LIT_HI 7
`define LIT_LO 0

// opcode patterns
`define OP7_INCR_SKIP_NZ 7'h12
`define OP7_OR_W_FILE 7'h04
`define OP8_OR_LIT_W 8'hb3
`define OP8_LONG_CALL 8'hb7

// values
`define BYTE_ZERO 8'h00
`define BYTE_ONE 8'h01
`define PC_ONE 16'h0001
`define WORD_ZERO 16'h0000

`endif

// File: src/incr_skip_or_longcall_exec.v
/*
  execution of four instructions of an 8-bit core: increment file and skip if
  non-zero, or literal into the working register, or working register with
  file, and long call. assumes a file register array that answers file_addr
  combinationally on file_rd_data within one mclk, a fetch unit that offers
  the next instruction word at each decode phase, and a stack that takes
  stack_push with top_of_stack.
*/
`timescale 1ns/1ps
`default_nettype none
`include "exec_map.vh"

// Behaviour
// - non-zero increment result discards the prefetched word, runs a no-op instead
// - increment-skip is one word, one cycle, two with skip; extra cycle does nothing
// - 1011 0011 kkkk kkkk ors literal with working register into working register
// - 0000 100d ffff ffff ors w with file into w or file, one cycle
// - long call 1011 0111 kkkk kkkk pushes program counter plus one
// - long call loads pc: literal low byte, holding latch high byte
module incr_skip_or_longcall_exec #(
  parameter DATA_W = 8,
  parameter INSTR_W = 16,
  parameter PC_W = 16
) (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // instruction fetch
  input wire instr_valid,
  input wire [INSTR_W-1:0] instr_word,
  input wire [PC_W-1:0] pc,
  input wire [DATA_W-1:0] pc_high_holding_latch,
  output reg [1:0] phase_reg,
  output reg instr_taken_reg,
  output reg discard_fetched_reg,
  // file register access
  output reg [DATA_W-1:0] file_addr_reg,
  input wire [DATA_W-1:0] file_rd_data,
  output reg file_wr_en_reg,
  output reg [DATA_W-1:0] file_wr_data_reg,
  // core state
  output reg [DATA_W-1:0] working_register_reg,
  output reg zero_flag_reg,
  // stack and program counter
  output reg stack_push_reg,
  output reg [PC_W-1:0] top_of_stack_reg,
  output reg pc_load_reg,
  output reg [PC_W-1:0] pc_load_value_reg
);

  reg [INSTR_W-1:0] instr_reg;
  reg active_reg;
  reg nop_pending_reg;
  reg [PC_W-1:0] pc_reg;
  reg [DATA_W-1:0] operand_reg;
  reg [DATA_W-1:0] result_reg;
  reg [DATA_W-1:0] result_next;

  wire [6:0] op7 = instr_reg[`OP7_HI:`OP7_LO];
  wire [7:0] op8 = instr_reg[`OP7_HI:`OP8_LO];
  wire dest_file = instr_reg[`DEST_BIT];
  wire [DATA_W-1:0] literal = instr_reg[`LIT_HI:`LIT_LO];
  wire is_incr = active_reg && (op7 == `OP7_INCR_SKIP_NZ);
  wire is_or_file = active_reg && (op7 == `OP7_OR_W_FILE);
  wire is_or_lit = active_reg && (op8 == `OP8_OR_LIT_W);
  wire is_call = active_reg && (op8 == `OP8_LONG_CALL);
  wire takes_file = is_incr || is_or_file;
  wire is_or = is_or_file || is_or_lit;

  // increment by one, wraps at the byte boundary
  // or of w and operand, shared by the file form
  always @*
  begin
    result_next = result_reg;
    if (is_incr)
    begin
      result_next = operand_reg + `BYTE_ONE;
    end
    else if (is_or)
    begin
      result_next = working_register_reg | operand_reg;
    end
  end

  // phases advance in fixed order, decode first after reset
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      phase_reg <= `PH_DECODE;
    end
    else
    begin
      phase_reg <= phase_reg + `PH_STEP;
    end
  end

  // file destination when d is set
  // the file form of or writes back the same way
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      file_wr_en_reg <= 1'h0;
      file_wr_data_reg <= `BYTE_ZERO;
    end
    else
    begin
      file_wr_en_reg <= 1'h0;
      if (takes_file && dest_file && (phase_reg == `PH_WRITE))
      begin
        file_wr_en_reg <= 1'h1;
        file_wr_data_reg <= result_reg;
      end
    end
  end

  // return address pushed in the same pulse as the load
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      stack_push_reg <= 1'h0;
      top_of_stack_reg <= `WORD_ZERO;
      pc_load_reg <= 1'h0;
      pc_load_value_reg <= `WORD_ZERO;
    end
    else
    begin
      stack_push_reg <= 1'h0;
      pc_load_reg <= 1'h0;
      if (is_call && (phase_reg == `PH_WRITE))
      begin
        stack_push_reg <= 1'h1;
        top_of_stack_reg <= pc_reg + `PC_ONE;
        // new pc from latch and literal
        pc_load_reg <= 1'h1;
        pc_load_value_reg <= {pc_high_holding_latch, literal};
      end
    end
  end

  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      instr_taken_reg <= 1'h0;
      discard_fetched_reg <= 1'h0;
      file_addr_reg <= `BYTE_ZERO;
      working_register_reg <= `BYTE_ZERO;
      zero_flag_reg <= 1'h0;
      instr_reg <= `WORD_ZERO;
      active_reg <= 1'h0;
      nop_pending_reg <= 1'h0;
      pc_reg <= `WORD_ZERO;
      operand_reg <= `BYTE_ZERO;
      result_reg <= `BYTE_ZERO;
    end
    else
    begin
      instr_taken_reg <= 1'h0;
      case (phase_reg)
        `PH_DECODE:
        begin
          // a pending no-op cycle takes no instruction in any phase
          if (nop_pending_reg)
          begin
            nop_pending_reg <= 1'h0;
            discard_fetched_reg <= 1'h1;
            active_reg <= 1'h0;
          end
          else
          begin
            discard_fetched_reg <= 1'h0;
            active_reg <= instr_valid;
            instr_taken_reg <= instr_valid;
            instr_reg <= instr_word;
            pc_reg <= pc;
            file_addr_reg <= instr_word[`LIT_HI:`LIT_LO];
          end
        end
        `PH_READ:
        begin
          // operand is file data or the literal
          if (takes_file)
            operand_reg <= file_rd_data;
          else
            operand_reg <= literal;
        end
        `PH_PROCESS:
        begin
          result_reg <= result_next;
        end
        `PH_WRITE:
        begin
          // destination chosen by the d bit
          // same destination choice for the file form of or
          if ((takes_file && !dest_file) || is_or_lit)
            working_register_reg <= result_reg;
          // only the or forms touch the zero flag
          // zero flag follows the or result
          if (is_or)
            zero_flag_reg <= (result_reg == `BYTE_ZERO);
          // non-zero result throws away the prefetched word
          if (is_incr && (result_reg != `BYTE_ZERO))
            nop_pending_reg <= 1'h1;
          // the prefetched word is stale after a call, so its cycle is a no-op
          if (is_call)
            nop_pending_reg <= 1'h1;
        end
        default:
        begin
          active_reg <= 1'h0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// File: testbench/exec_chk_sva.sv
/* timing checks of the execution block; bound to its top ports, one mclk domain */
`timescale 1ns/1ps
`default_nettype none
module exec_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // fetch side
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [15:0] pc,
  input wire logic [7:0] pc_high_holding_latch,
  input wire logic [1:0] phase_reg,
  input wire logic instr_taken_reg,
  input wire logic discard_fetched_reg,
  // results
  input wire logic file_wr_en_reg,
  input wire logic [7:0] working_register_reg,
  input wire logic zero_flag_reg,
  input wire logic stack_push_reg,
  input wire logic [15:0] top_of_stack_reg,
  input wire logic pc_load_reg,
  input wire logic [15:0] pc_load_value_reg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence noop_cycle;
    discard_fetched_reg [*4];
  endsequence
  phase_order_a: assert property ($past(rstn) |-> phase_reg == $past(phase_reg) + 2'h1)
    else $error("phase skipped");
  taken_src_a: assert property (instr_taken_reg |-> $past(instr_valid) && $past(phase_reg) == 2'h0)
    else $error("stray take");
  noop_quiet_a: assert property (discard_fetched_reg |-> !instr_taken_reg)
    else $error("take in no-op");
  wr_pulse_a: assert property (file_wr_en_reg |-> phase_reg == 2'h0 ##1 !file_wr_en_reg)
    else $error("bad write pulse");
  call_pair_a: assert property (stack_push_reg |-> pc_load_reg ##1 noop_cycle)
    else $error("bad call cycle");
  call_addr_a: assert property (pc_load_reg |-> pc_load_value_reg == {$past(pc_high_holding_latch),
    $past(instr_word[7:0], 4)} && top_of_stack_reg == $past(pc, 4) + 16'h1)
    else $error("bad call address");
  incr_flag_a: assert property (instr_taken_reg && $past(instr_word[15:9]) == 7'h12 |->
    ##3 $stable(zero_flag_reg))
    else $error("increment moved flag");
  or_zero_a: assert property (instr_taken_reg && $past(instr_word[15:8]) == 8'hb3 |->
    ##3 zero_flag_reg == (working_register_reg == 8'h00))
    else $error("bad zero flag");
endmodule
bind incr_skip_or_longcall_exec exec_chk exec_chk_inst (
  .mclk(mclk),
  .rstn(rstn),
  .instr_valid(instr_valid),
  .instr_word(instr_word),
  .pc(pc),
  .pc_high_holding_latch(pc_high_holding_latch),
  .phase_reg(phase_reg),
  .instr_taken_reg(instr_taken_reg),
  .discard_fetched_reg(discard_fetched_reg),
  .file_wr_en_reg(file_wr_en_reg),
  .working_register_reg(working_register_reg),
  .zero_flag_reg(zero_flag_reg),
  .stack_push_reg(stack_push_reg),
  .top_of_stack_reg(top_of_stack_reg),
  .pc_load_reg(pc_load_reg),
  .pc_load_value_reg(pc_load_value_reg)
);
`default_nettype wire

// File: testbench/incr_skip_or_longcall_exec_tb_top.sv
/* bench of the execution block; drives fetch and file read ports itself */
`timescale 1ns/1ps
`default_nettype none
module incr_skip_or_longcall_exec_tb_top;
  logic mclk = 0, rstn = 0, instr_valid = 0;
  logic [15:0] instr_word = 0, pc = 16'h1234;
  logic [7:0] latch = 8'hab, rd = 0;
  wire [1:0] ph;
  wire tk, dis, wen, zf, push, ld;
  wire [7:0] fa, wd, w;
  wire [15:0] top_of_stack, lv;
  int n_mismatch = 0, n_tests = 0;
  incr_skip_or_longcall_exec incr_skip_or_longcall_exec_inst (.mclk(mclk), .rstn(rstn),
    .instr_valid(instr_valid), .instr_word(instr_word), .pc(pc), .pc_high_holding_latch(latch),
    .phase_reg(ph), .instr_taken_reg(tk), .discard_fetched_reg(dis), .file_addr_reg(fa),
    .file_rd_data(rd), .file_wr_en_reg(wen), .file_wr_data_reg(wd), .working_register_reg(w),
    .zero_flag_reg(zf), .stack_push_reg(push), .top_of_stack_reg(top_of_stack), .pc_load_reg(ld),
    .pc_load_value_reg(lv));
  initial forever #4 mclk = ~mclk;
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task final_report;
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // bounded wait for a write phase; a hang counts as a mismatch
  task automatic wait_write;
    int i;
    for (i = 0; i < 20 && ph !== 2'h3; i++)
      @(negedge mclk);
    if (i == 20)
    begin
      n_mismatch++;
      final_report();
    end
  endtask
  // offer a word in a decode phase, return once its results have landed
  task automatic exec(input logic [15:0] iw, input logic [7:0] fd);
    wait_write();
    @(posedge mclk);
    instr_word <= iw;
    rd <= fd;
    instr_valid <= 1'h1;
    @(posedge mclk);
    instr_valid <= 1'h0;
    @(negedge mclk);
    chk({ph, tk}, 3'h3);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask
  // two words in consecutive decode phases; take2 says whether the second one runs
  task automatic pair(input logic [15:0] iw1, input logic [15:0] iw2, input logic [7:0] fd,
    input logic take2);
    wait_write();
    @(posedge mclk);
    instr_word <= iw1;
    rd <= fd;
    instr_valid <= 1'h1;
    @(posedge mclk);
    instr_word <= iw2;
    @(negedge mclk);
    chk(tk, 1'h1);
    repeat (4) @(posedge mclk);
    instr_valid <= 1'h0;
    @(negedge mclk);
    chk(tk, take2);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic skip(input logic e);
    @(negedge mclk);
    chk(dis, e);
  endtask
  task automatic t_or_lit;
    exec(16'hb300, 8'h00);
    chk({w, zf}, 9'h001);
    exec(16'hb39a, 8'h00);
    exec(16'hb335, 8'h00);
    chk({wen, w, zf}, 10'h17e);
  endtask
  task automatic t_or_file;
    exec(16'h0811, 8'h40);
    chk({wen, zf, w}, 10'h0ff);
    exec(16'h0905, 8'h00);
    chk({wen, fa, wd, w}, 25'h105ffff);
  endtask
  task automatic t_incr;
    exec(16'h25aa, 8'hff);
    chk({wen, fa, wd, zf}, 18'h35400);
    skip(1'b0);
    exec(16'h2407, 8'h41);
    chk({wen, w, zf}, 10'h084);
    skip(1'h1);
    pair(16'h2407, 16'hb380, 8'h10, 1'h0);
    chk({w, dis}, 9'h023);
    pair(16'h24ff, 16'hb300, 8'hff, 1'h1);
    chk({w, zf, dis}, 10'h002);
    exec(16'h2507, 8'h10);
    chk({wen, wd, zf}, 10'h223);
    skip(1'h1);
  endtask
  task automatic t_call;
    exec(16'hb7cd, 8'h00);
    chk({push, ld, top_of_stack, lv}, 34'h31235abcd);
    skip(1'b1);
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    t_or_lit();
    t_or_file();
    t_incr();
    t_call();
    final_report();
  end
endmodule
`default_nettype wire
